// ### src/dmd_decoder.v
/*
  decodes and executes 16-bit data-move instructions of a 32-bit core,
  plus operand field handling of branch and multiply-accumulate formats.
  assumes the fetch stage holds instr_valid with a stable word and pc until
  taken, and the load/store path answers each mem_req with one mem_ack.
*/
// Behaviour
// - immediate move sign-extends the 8-bit field into the selected register
// - word load from pc plus displacement times 2, sign-extended
// - longword load from aligned pc plus displacement times 4, unchanged
// - register-to-register copy, no memory access
// - store source as byte, word or longword at address in destination
// - load byte, word or longword from source address, sign-extend small
// - pre-decrement destination by size, then store at new address
// - post-increment load: load, then add size to source register
// - store register zero byte or word at destination plus scaled disp
// - store longword at destination plus displacement times 4
// - load byte or word from source plus scaled disp into register zero
// - load longword from source plus displacement times 4
// - store low byte of source at register zero plus destination
// - all moves legal in user mode, one-cycle issue, test flag untouched
// - 12-bit displacement format gives branch target pc plus displacement
// - multiply-accumulate uses the nnnn field as a source operand
// - register zero moves to and from global base plus scaled 8-bit disp
`include "dmd_defines.vh"
module dmd_decoder #(
  parameter DW = `DMD_DW,
  parameter AW = `DMD_RIDX_W
) (
  input wire ref_clk, // core clock, 20 MHz
  input wire reset_n, // async reset, active low
  input wire instr_valid, // fetch offers a word
  input wire [15:0] instr_word, // instruction word
  input wire [DW-1:0] instr_pc, // address of the instruction
  output reg instr_ready, // decoder takes a word this cycle
  input wire [DW-1:0] global_base_register, // base of register-zero moves
  output reg mem_req, // memory access pending
  output reg mem_we, // 1 store, 0 load
  output reg [1:0] mem_size, // byte, word, longword
  output reg [DW-1:0] mem_addr, // access address
  output reg [DW-1:0] mem_wdata, // store data, right-aligned
  input wire mem_ack, // access completes
  input wire [DW-1:0] mem_rdata, // load data, right-aligned
  output reg retire, // instruction finished pulse
  output reg illegal_instr, // word not handled pulse
  output reg branch_valid, // branch target valid pulse
  output reg [DW-1:0] branch_target, // computed branch target
  output reg mac_valid, // mac operands valid pulse
  output reg [DW-1:0] mac_op_n, // mac operand from nnnn
  output reg [DW-1:0] mac_op_m, // mac operand from mmmm
  input wire [AW-1:0] dbg_sel, // debug register select
  output reg [DW-1:0] dbg_data // selected register, one cycle late
);
  // size in bytes of an access code
  function [DW-1:0] size_bytes;
    input [1:0] sz;
    begin
      size_bytes = {{(DW-3){1'b0}}, 3'h1} << sz;
    end
  endfunction

  // zero-extended displacement scaled by access size
  function [DW-1:0] scale_disp;
    input [7:0] disp;
    input [1:0] sz;
    begin
      scale_disp = {{(DW-8){1'b0}}, disp} << sz;
    end
  endfunction

  reg state;
  reg [AW-1:0] pend_dst;
  reg [1:0] pend_size;
  reg pend_post;
  reg [AW-1:0] pend_post_idx;
  reg [DW-1:0] pend_post_val;
  reg pend_post_only;

  wire [3:0] op = instr_word[15:12];
  wire [3:0] fn = instr_word[11:8];
  wire [3:0] fm = instr_word[7:4];
  wire [3:0] lo = instr_word[3:0];
  wire [7:0] d8 = instr_word[7:0];
  wire [7:0] d4 = {4'h0, instr_word[3:0]};
  // longword pc-relative accesses use an aligned pc
  wire [DW-1:0] pc_aligned = {instr_pc[DW-1:2], 2'h0};

  wire [DW-1:0] val_n;
  wire [DW-1:0] val_m;
  wire [DW-1:0] val_zero;
  wire [DW-1:0] val_dbg;
  wire [DW-1:0] load_val;

  // a word is taken only while no access is outstanding
  wire take = instr_valid && instr_ready;
  // an ack outside an access is ignored
  wire ack = (state == `DMD_ST_MEM) && mem_req && mem_ack;

  // decode results
  reg [2:0] d_kind;
  reg [AW-1:0] d_dst;
  reg [DW-1:0] d_val;
  reg [DW-1:0] d_addr;
  reg [1:0] d_size;
  reg [DW-1:0] d_wdata;
  reg d_pre;
  reg d_post;
  reg [DW-1:0] d_upd_val;

  // no privilege check and no flag output: every move is legal and
  // leaves the test flag as it was
  always @* begin
    d_kind = `DMD_K_NONE;
    d_dst = fn;
    d_val = {DW{1'b0}};
    d_addr = {DW{1'b0}};
    d_size = `DMD_SZ_LONG;
    d_wdata = val_m;
    d_pre = 1'b0;
    d_post = 1'b0;
    d_upd_val = {DW{1'b0}};
    case (op)
      `DMD_OP_IMM: begin
        d_kind = `DMD_K_REG;
        d_val = {{(DW-8){d8[7]}}, d8};
      end
      `DMD_OP_PC_WORD: begin
        d_kind = `DMD_K_LOAD;
        d_size = `DMD_SZ_WORD;
        d_addr = instr_pc + scale_disp(d8, `DMD_SZ_WORD);
      end
      `DMD_OP_PC_LONG: begin
        d_kind = `DMD_K_LOAD;
        d_addr = pc_aligned + scale_disp(d8, `DMD_SZ_LONG);
      end
      `DMD_OP_IND_LD: begin
        if (lo == `DMD_LO_MOVE) begin
          d_kind = `DMD_K_REG;
          d_val = val_m;
        end else if (lo[3] == 1'b0 && lo[1:0] != 2'h3) begin
          d_kind = `DMD_K_LOAD;
          d_size = lo[1:0];
          d_addr = val_m;
          d_post = lo[2];
          d_upd_val = val_m + size_bytes(lo[1:0]);
        end
      end
      `DMD_OP_IND_ST: begin
        if (lo[3] == 1'b0 && lo[1:0] != 2'h3) begin
          d_kind = `DMD_K_STORE;
          d_size = lo[1:0];
          d_pre = lo[2];
          d_upd_val = val_n - size_bytes(lo[1:0]);
          // pre-decrement addresses with the reduced base
          d_addr = lo[2] ? d_upd_val : val_n;
        end
      end
      `DMD_OP_R0_DISP: begin
        d_size = fn[1:0];
        // base sits in bits 7:4 in both directions
        d_addr = val_m + scale_disp(d4, fn[1:0]);
        d_wdata = val_zero;
        d_dst = {AW{1'b0}};
        if (fn == 4'h0 || fn == 4'h1) begin
          d_kind = `DMD_K_STORE;
        end else if (fn == 4'h4 || fn == 4'h5) begin
          d_kind = `DMD_K_LOAD;
        end
      end
      `DMD_OP_DISP_ST: begin
        d_kind = `DMD_K_STORE;
        d_addr = val_n + scale_disp(d4, `DMD_SZ_LONG);
      end
      `DMD_OP_DISP_LD: begin
        d_kind = `DMD_K_LOAD;
        d_addr = val_m + scale_disp(d4, `DMD_SZ_LONG);
      end
      `DMD_OP_IDX_ST: begin
        if (lo == `DMD_LO_IDX_BYTE) begin
          d_kind = `DMD_K_STORE;
          d_size = `DMD_SZ_BYTE;
          d_addr = val_zero + val_n;
        end else if (lo == `DMD_LO_MAC) begin
          d_kind = `DMD_K_MAC;
        end
      end
      `DMD_OP_MACW: begin
        if (lo == `DMD_LO_MAC) begin
          d_kind = `DMD_K_MAC;
        end
      end
      `DMD_OP_BRANCH: begin
        d_kind = `DMD_K_BRANCH;
        // branch displacement is not scaled
        d_val = instr_pc + {{(DW-12){fn[3]}}, instr_word[11:0]};
      end
      `DMD_OP_BASE_REL: begin
        d_size = fn[1:0];
        d_dst = {AW{1'b0}};
        d_wdata = val_zero;
        d_addr = global_base_register + scale_disp(d8, fn[1:0]);
        // sub-code 7 puts an aligned pc-relative address in register zero
        if (fn == `DMD_SUB_EA) begin
          d_kind = `DMD_K_REG;
          d_val = pc_aligned + scale_disp(d8, `DMD_SZ_LONG);
        end else if (fn[3] == 1'b0 && fn[1:0] != 2'h3) begin
          d_kind = fn[2] ? `DMD_K_LOAD : `DMD_K_STORE;
        end
      end
      default: begin
        d_kind = `DMD_K_NONE;
      end
    endcase
  end

  // port a: immediate, copy, address and load results
  // port b: pre-decrement at issue, post-increment at completion
  // port a wins, so a load beats the increment on a shared index
  wire issue_reg = take && d_kind == `DMD_K_REG;
  wire issue_pre = take && d_kind == `DMD_K_STORE && d_pre;
  wire wr_a_en = issue_reg || (ack && !pend_post_only);
  wire [AW-1:0] wr_a_idx = ack ? pend_dst : d_dst;
  wire [DW-1:0] wr_a_data = ack ? load_val : d_val;
  wire wr_b_en = issue_pre || (ack && pend_post);
  wire [AW-1:0] wr_b_idx = ack ? pend_post_idx : fn;
  wire [DW-1:0] wr_b_data = ack ? pend_post_val : d_upd_val;

  dmd_regfile #(
    .DW(DW),
    .AW(AW)
  ) u_regs (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .rd_a_idx(fn),
    .rd_a_data(val_n),
    .rd_b_idx(fm),
    .rd_b_data(val_m),
    .rd_zero_data(val_zero),
    .rd_dbg_idx(dbg_sel),
    .rd_dbg_data(val_dbg),
    .wr_a_en(wr_a_en),
    .wr_a_idx(wr_a_idx),
    .wr_a_data(wr_a_data),
    .wr_b_en(wr_b_en),
    .wr_b_idx(wr_b_idx),
    .wr_b_data(wr_b_data)
  );

  dmd_load_ext #(
    .DW(DW)
  ) u_ext (
    .size(pend_size),
    .raw(mem_rdata),
    .shaped(load_val)
  );

  // an access holds the fetch side off until its ack edge
  wire is_mem = d_kind == `DMD_K_LOAD || d_kind == `DMD_K_STORE;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= `DMD_ST_IDLE;
      instr_ready <= 1'b1;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_size <= `DMD_SZ_BYTE;
      mem_addr <= {DW{1'b0}};
      mem_wdata <= {DW{1'b0}};
      pend_dst <= {AW{1'b0}};
      pend_size <= `DMD_SZ_BYTE;
      pend_post <= 1'b0;
      pend_post_only <= 1'b0;
      pend_post_idx <= {AW{1'b0}};
      pend_post_val <= {DW{1'b0}};
      retire <= 1'b0;
      illegal_instr <= 1'b0;
      branch_valid <= 1'b0;
      branch_target <= {DW{1'b0}};
      mac_valid <= 1'b0;
      mac_op_n <= {DW{1'b0}};
      mac_op_m <= {DW{1'b0}};
      dbg_data <= {DW{1'b0}};
    end else begin
      retire <= 1'b0;
      illegal_instr <= 1'b0;
      branch_valid <= 1'b0;
      mac_valid <= 1'b0;
      // debug read: registered copy of the selected register
      dbg_data <= val_dbg;
      case (state)
        `DMD_ST_IDLE: begin
          if (take) begin
            if (is_mem) begin
              // access fields freeze until the ack edge
              state <= `DMD_ST_MEM;
              instr_ready <= 1'b0;
              mem_req <= 1'b1;
              mem_we <= d_kind == `DMD_K_STORE;
              mem_size <= d_size;
              mem_addr <= d_addr;
              mem_wdata <= d_wdata;
              pend_dst <= d_dst;
              pend_size <= d_size;
              pend_post <= d_post;
              pend_post_only <= d_kind == `DMD_K_STORE;
              pend_post_idx <= fm;
              pend_post_val <= d_upd_val;
            end else if (d_kind == `DMD_K_NONE) begin
              illegal_instr <= 1'b1;
            end else begin
              retire <= 1'b1;
            end
            if (d_kind == `DMD_K_BRANCH) begin
              branch_valid <= 1'b1;
              branch_target <= d_val;
            end
            if (d_kind == `DMD_K_MAC) begin
              mac_valid <= 1'b1;
              mac_op_n <= val_n;
              mac_op_m <= val_m;
            end
          end
        end
        `DMD_ST_MEM: begin
          // next word may be taken on the edge after the ack
          if (ack) begin
            state <= `DMD_ST_IDLE;
            instr_ready <= 1'b1;
            mem_req <= 1'b0;
            pend_post <= 1'b0;
            retire <= 1'b1;
          end
        end
        // unreachable code: recover to idle
        default: begin
          state <= `DMD_ST_IDLE;
          instr_ready <= 1'b1;
          mem_req <= 1'b0;
        end
      endcase
    end
  end
endmodule // dmd_decoder

// ### include/dmd_defines.vh
/*
  constants of the data-move decoder: opcode groups, sizes, states.
  assumes inclusion by bare name from the design files.
*/
`ifndef DMD_DEFINES_VH
`define DMD_DEFINES_VH

`define DMD_DW 32
`define DMD_NREG 16
`define DMD_RIDX_W 4

// top nibble groups
`define DMD_OP_IDX_ST 4'h0
`define DMD_OP_DISP_ST 4'h1
`define DMD_OP_IND_ST 4'h2
`define DMD_OP_MACW 4'h4
`define DMD_OP_DISP_LD 4'h5
`define DMD_OP_IND_LD 4'h6
`define DMD_OP_R0_DISP 4'h8
`define DMD_OP_PC_WORD 4'h9
`define DMD_OP_BRANCH 4'hA
`define DMD_OP_BASE_REL 4'hC
`define DMD_OP_PC_LONG 4'hD
`define DMD_OP_IMM 4'hE

// low nibble selectors, and the bits 11:8 sub-code of the base group
`define DMD_LO_MOVE 4'h3
`define DMD_LO_IDX_BYTE 4'h4
`define DMD_LO_MAC 4'hF
`define DMD_SUB_EA 4'h7

// access sizes, also the shift used to scale displacements
`define DMD_SZ_BYTE 2'h0
`define DMD_SZ_WORD 2'h1
`define DMD_SZ_LONG 2'h2

// states
`define DMD_ST_IDLE 1'h0
`define DMD_ST_MEM 1'h1

// decode classes
`define DMD_K_NONE 3'h0
`define DMD_K_REG 3'h1
`define DMD_K_LOAD 3'h2
`define DMD_K_STORE 3'h3
`define DMD_K_BRANCH 3'h4
`define DMD_K_MAC 3'h5

`endif

// ### src/dmd_regfile.v
/*
  general register file: flip-flop storage, three read ports plus a debug
  read, two write ports with port a taking priority on the same index.
  assumes single clock and active-low asynchronous reset.
*/
module dmd_regfile #(
  parameter DW = 32,
  parameter AW = 4
) (
  input wire ref_clk, // core clock
  input wire reset_n, // async reset, active low
  input wire [AW-1:0] rd_a_idx, // read port a index
  output wire [DW-1:0] rd_a_data, // read port a data
  input wire [AW-1:0] rd_b_idx, // read port b index
  output wire [DW-1:0] rd_b_data, // read port b data
  output wire [DW-1:0] rd_zero_data, // register zero
  input wire [AW-1:0] rd_dbg_idx, // debug read index
  output wire [DW-1:0] rd_dbg_data, // debug read data
  input wire wr_a_en, // write port a enable
  input wire [AW-1:0] wr_a_idx, // write port a index
  input wire [DW-1:0] wr_a_data, // write port a data
  input wire wr_b_en, // write port b enable
  input wire [AW-1:0] wr_b_idx, // write port b index
  input wire [DW-1:0] wr_b_data // write port b data
);
  reg [DW-1:0] regs [0:(1<<AW)-1];

  genvar gi;
  generate
    for (gi = 0; gi < (1 << AW); gi = gi + 1) begin : g_reg
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          regs[gi] <= {DW{1'b0}};
        end else if (wr_a_en && {{(32-AW){1'b0}}, wr_a_idx} == gi) begin
          regs[gi] <= wr_a_data;
        end else if (wr_b_en && {{(32-AW){1'b0}}, wr_b_idx} == gi) begin
          regs[gi] <= wr_b_data;
        end
      end
    end
  endgenerate

  assign rd_a_data = regs[rd_a_idx];
  assign rd_b_data = regs[rd_b_idx];
  assign rd_zero_data = regs[0];
  assign rd_dbg_data = regs[rd_dbg_idx];
endmodule // dmd_regfile

// ### src/dmd_load_ext.v
/*
  shapes returned load data: keeps the low byte or word and sign-extends
  it, or passes a longword unchanged.
  assumes load data arrives right-aligned in the low bits.
*/
`include "dmd_defines.vh"
module dmd_load_ext #(
  parameter DW = 32
) (
  input wire [1:0] size, // access size code
  input wire [DW-1:0] raw, // data from memory
  output reg [DW-1:0] shaped // value for the register
);
  always @* begin
    case (size)
      `DMD_SZ_BYTE: shaped = {{(DW-8){raw[7]}}, raw[7:0]};
      `DMD_SZ_WORD: shaped = {{(DW-16){raw[15]}}, raw[15:0]};
      default: shaped = raw;
    endcase
  end
endmodule // dmd_load_ext

// ### bench/dmd_decoder_asserts.sv
/*
  port checker for dmd_decoder, bound to every instance.
  assumes one clock and an active-low asynchronous reset.
*/
module dmd_decoder_asserts (
  input wire logic ref_clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic instr_valid, // fetch offers a word
  input wire logic [15:0] instr_word, // instruction word
  input wire logic [31:0] instr_pc, // instruction address
  input wire logic instr_ready, // decoder takes a word
  input wire logic [31:0] global_base_register, // base of register-zero moves
  input wire logic mem_req, // access pending
  input wire logic mem_we, // store when high
  input wire logic [1:0] mem_size, // access size
  input wire logic [31:0] mem_addr, // access address
  input wire logic [31:0] mem_wdata, // store data
  input wire logic mem_ack, // access completes
  input wire logic retire, // instruction done
  input wire logic illegal_instr, // word refused
  input wire logic branch_valid, // target valid
  input wire logic [31:0] branch_target, // branch target
  input wire logic mac_valid // mac operands valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] p_w;
  logic [31:0] p_pc, p_g;
  wire take = instr_valid && instr_ready;
  wire [3:0] op = instr_word[15:12];
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // copies of the taken word, pc and base one edge late
  always @(posedge ref_clk) begin
    p_w <= instr_word;
    p_pc <= instr_pc;
    p_g <= global_base_register;
  end
  a_busy_refuse:
    assert property (mem_req |-> !instr_ready) else $error("ready in access");
  a_access_hold:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
      && $stable(mem_size) && $stable(mem_we) && $stable(mem_wdata))
      else $error("access changed before ack");
  a_ack_retire:
    assert property (mem_req && mem_ack |=> !mem_req && retire && instr_ready)
      else $error("no retire after ack");
  a_imm_single:
    assert property (take && op == 4'hE |=> retire && !mem_req
      && !illegal_instr) else $error("immediate move not one cycle");
  a_copy_nomem:
    assert property (take && op == 4'h6 && instr_word[3:0] == 4'h3
      |=> retire && !mem_req) else $error("copy touched memory");
  a_branch_sum:
    assert property (take && op == 4'hA |=> branch_valid && branch_target
      == p_pc + {{20{p_w[11]}}, p_w[11:0]}) else $error("bad target");
  a_pcl_addr:
    assert property (take && op == 4'hD |=> mem_req && !mem_we && mem_size
      == 2'h2 && mem_addr == (p_pc & ~32'h3) + {p_w[7:0], 2'h0})
      else $error("bad pc long address");
  a_pcw_addr:
    assert property (take && op == 4'h9 |=> mem_req && !mem_we && mem_size
      == 2'h1 && mem_addr == p_pc + {p_w[7:0], 1'b0})
      else $error("bad pc word address");
  a_base_store:
    assert property (take && instr_word[15:8] == 8'hC1 |=> mem_req && mem_we
      && mem_size == 2'h1 && mem_addr == p_g + {p_w[7:0], 1'b0})
      else $error("bad base store");
  a_long_disp:
    assert property (take && op == 4'h1 |=> mem_req && mem_we
      && mem_size == 2'h2) else $error("bad long store");
  a_mac_src:
    assert property (take && (op == 4'h0 || op == 4'h4)
      && instr_word[3:0] == 4'hF |=> mac_valid && !mem_req)
      else $error("mac operands missing");
  c_slow: cover property (mem_req && !mem_ack ##1 mem_ack);
  c_b2b: cover property (retire ##1 retire);
  c_bad: cover property (illegal_instr);
  c_store: cover property (mem_req && mem_ack && mem_we);
endmodule // dmd_decoder_asserts

bind dmd_decoder dmd_decoder_asserts u_chk (.ref_clk, .reset_n, .instr_valid,
  .instr_word, .instr_pc, .instr_ready, .global_base_register, .mem_req,
  .mem_we, .mem_size, .mem_addr, .mem_wdata, .mem_ack, .retire,
  .illegal_instr, .branch_valid, .branch_target, .mac_valid);

// ### bench/dmd_mem_model.sv
/*
  load/store path model: acks after a chosen wait, data from the address.
  assumes requests hold until acked; drives on the falling edge.
*/
module dmd_mem_model (
  input wire logic ref_clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic mem_req, // access pending
  input wire logic [31:0] mem_addr, // access address
  input wire logic [1:0] delay, // wait cycles before ack
  output logic mem_ack, // completion pulse
  output logic [31:0] mem_rdata // load data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt;
  always @(negedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_ack <= 1'b0;
      cnt <= 2'h0;
      mem_rdata <= 32'h0;
    end else if (mem_req && !mem_ack && cnt >= delay) begin
      mem_ack <= 1'b1;
      cnt <= 2'h0;
      mem_rdata <= mem_addr * 32'h9E3779B1;
    end else begin
      mem_ack <= 1'b0;
      cnt <= (mem_req && !mem_ack) ? cnt + 2'h1 : 2'h0;
      // no stale data between answers
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // dmd_mem_model

// ### bench/tb_data_move_instruction_decoder.sv
/*
  bench for dmd_decoder: random data moves against a behavioural model.
  assumes the memory model answers every access.
*/
module tb_data_move_instruction_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, s) begin total_checks++; if ((s) !== (e)) begin \
    n_mismatch++; $display("Error %s exp %h got %h", nm, e, s); end end
  logic ref_clk = 0, reset_n = 0, instr_valid = 0;
  logic [15:0] instr_word = 0;
  logic [31:0] instr_pc = 0, global_base_register = 0;
  logic [3:0] dbg_sel = 0;
  logic [1:0] delay = 0;
  logic instr_ready, mem_req, mem_we, mem_ack, retire, illegal_instr;
  logic branch_valid, mac_valid, e_we, e_mem, e_ill, e_br, e_mac, s_we, s_mem;
  logic [1:0] mem_size, e_sz, s_sz;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, branch_target, mac_op_n;
  logic [31:0] mac_op_m, dbg_data, e_ad, e_wd, e_tgt, e_mn, e_mm;
  logic [31:0] s_ad, s_wd, s_tgt, s_mn, s_mm;
  logic [31:0] r [16];
  int n_mismatch = 0, total_checks = 0, e_ld;
  dmd_decoder dut (.ref_clk, .reset_n, .instr_valid, .instr_word, .instr_pc,
    .instr_ready, .global_base_register, .mem_req, .mem_we, .mem_size,
    .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .retire, .illegal_instr,
    .branch_valid, .branch_target, .mac_valid, .mac_op_n, .mac_op_m,
    .dbg_sel, .dbg_data);
  dmd_mem_model mem (.ref_clk, .reset_n, .mem_req, .mem_addr, .delay,
    .mem_ack, .mem_rdata);
  initial forever #25 ref_clk = ~ref_clk;
  function automatic logic [31:0] ext(input logic [1:0] sz,
      input logic [31:0] v);
    if (sz == 2'h0) return {{24{v[7]}}, v[7:0]};
    if (sz == 2'h1) return {{16{v[15]}}, v[15:0]};
    return v;
  endfunction
  task automatic model(input logic [15:0] w, input logic [31:0] pc);
    logic [3:0] n, m, d;
    logic [7:0] d8;
    logic [31:0] a;
    n = w[11:8]; m = w[7:4]; d = w[3:0]; d8 = w[7:0]; a = 0;
    e_we = 0; e_sz = 2'h2; e_ill = 0; e_br = 0; e_mac = 0; e_ld = 16;
    case (w[15:12])
      4'hE: r[n] = {{24{d8[7]}}, d8};
      4'h9: begin e_sz = 2'h1; a = pc + {d8, 1'b0}; e_ld = n; end
      4'hD: begin a = (pc & ~32'h3) + {d8, 2'h0}; e_ld = n; end
      4'h6: if (d == 4'h3) r[n] = r[m];
        else begin
          e_sz = d[1:0]; a = r[m]; e_ld = n;
          if (d[2]) r[m] = r[m] + (32'h1 << d[1:0]);
        end
      4'h2: begin
        e_we = 1; e_sz = d[1:0]; e_wd = r[m];
        if (d[2]) r[n] = r[n] - (32'h1 << d[1:0]);
        a = r[n];
      end
      4'h8: begin
        e_sz = {1'b0, n[0]}; a = r[m] + (32'(d) << n[0]);
        if (n[2]) e_ld = 0; else begin e_we = 1; e_wd = r[0]; end
      end
      4'h1: begin e_we = 1; e_wd = r[m]; a = r[n] + {d, 2'h0}; end
      4'h5: begin a = r[m] + {d, 2'h0}; e_ld = n; end
      4'h0, 4'h4: if (d == 4'h4 && !w[14]) begin
          e_we = 1; e_sz = 2'h0; e_wd = r[m]; a = r[0] + r[n];
        end else begin e_mac = 1; e_mn = r[n]; e_mm = r[m]; end
      4'hA: begin e_br = 1; e_tgt = pc + {{20{w[11]}}, w[11:0]}; end
      4'hC: if (n == 4'h7) r[0] = (pc & ~32'h3) + {d8, 2'h0};
        else if (n == 4'h3) e_ill = 1;
        else begin
          e_sz = n[1:0]; a = global_base_register + (32'(d8) << n[1:0]);
          if (n[2]) e_ld = 0; else begin e_we = 1; e_wd = r[0]; end
        end
      default: e_ill = 1;
    endcase
    e_mem = e_we || e_ld < 16;
    e_ad = a;
    if (e_ld < 16) r[e_ld] = ext(e_sz, a * 32'h9E3779B1);
  endtask
  function automatic logic [15:0] gen();
    logic [15:0] w;
    int k;
    w = 16'($urandom); k = $urandom % 6;
    case (w[15:12])
      4'h0: w[3:0] = w[0] ? 4'h4 : 4'hF;
      4'h2: w[3:0] = 4'(k + (k > 2));
      4'h4: w[3:0] = 4'hF;
      4'h6: w[3:0] = 4'($urandom % 7);
      4'h8: w[11:8] = {1'b0, w[10], 1'b0, w[8]};
      4'hC: w[11] = 1'b0;
      default: ;
    endcase
    // keep base and data register apart for stepping moves
    if (w[15:12] ==? 4'b0?10 && w[2] && w[11:8] == w[7:4]) w[4] = ~w[4];
    return w;
  endfunction
  task automatic chk_reg(input logic [3:0] i);
    dbg_sel = i;
    @(negedge ref_clk); #1;
    `CHK("register", r[i], dbg_data)
  endtask
  task automatic run(input logic [15:0] w, input logic [31:0] pc);
    int k;
    logic [31:0] mk;
    model(w, pc);
    instr_valid = 1; instr_word = w; instr_pc = pc;
    s_mem = 0; s_tgt = 'x; s_mn = 'x; s_mm = 'x; k = 0;
    do begin
      @(negedge ref_clk); #1; k++;
      if (k == 1) instr_valid = 0;
      if (mem_req === 1'b1 && mem_ack === 1'b1) begin
        s_mem = 1; s_we = mem_we; s_sz = mem_size; s_ad = mem_addr;
        s_wd = mem_wdata;
      end
      if (branch_valid === 1'b1) s_tgt = branch_target;
      if (mac_valid === 1'b1) begin s_mn = mac_op_n; s_mm = mac_op_m; end
    end while (retire !== 1'b1 && illegal_instr !== 1'b1 && k < 40);
    `CHK("done", 1'b1, retire | illegal_instr)
    mk = ~(32'hFFFFFFFF << (8 << e_sz));
    `CHK("access", e_mem, s_mem)
    `CHK("illegal", e_ill, illegal_instr)
    if (e_mem && s_mem) begin
      `CHK("addr", e_ad, s_ad)
      `CHK("dir", e_we, s_we)
      `CHK("size", e_sz, s_sz)
      if (e_we) `CHK("wdata", e_wd & mk, s_wd & mk)
    end
    if (e_br) `CHK("target", e_tgt, s_tgt)
    if (e_mac) `CHK("mac", {e_mn, e_mm}, {s_mn, s_mm})
    chk_reg(w[11:8]);
    chk_reg(w[7:4]);
    chk_reg(4'h0);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(50 * 30000);
    n_mismatch++;
    give_verdict();
  end
  initial begin
    void'($urandom(25));
    for (int i = 0; i < 16; i++) r[i] = 0;
    repeat (12) @(negedge ref_clk);
    reset_n = 1;
    #1;
    `CHK("ready", 1'b1, instr_ready)
    `CHK("req", 1'b0, mem_req)
    for (int i = 0; i < 16; i++) chk_reg(4'(i));
    // immediate moves offered every cycle
    for (int i = 0; i < 9; i++) begin
      if (i > 0) `CHK("retire", 1'b1, retire)
      instr_valid = i < 8;
      instr_word = {4'hE, 4'(i), 8'($urandom)};
      if (i < 8) model(instr_word, 0);
      @(negedge ref_clk); #1;
    end
    for (int i = 0; i < 8; i++) chk_reg(4'(i));
    repeat (400) begin
      delay = 2'($urandom % 3);
      global_base_register = $urandom;
      run(gen(), $urandom);
    end
    give_verdict();
  end
endmodule // tb_data_move_instruction_decoder
